// [logic/bpi_pkg.sv]
package bpi_pkg;
  // geometry
  localparam int ADDR_W     = 22;
  localparam int DATA_W     = 16;
  localparam int AXI_AW     = 8;
  localparam int BEAT_W     = 9;

  // timing, aclk period in ns
  localparam int CLK_NS     = 10;
  localparam int PU_US      = 200;
  localparam int PU_CYC_DEF = (PU_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PAR_NS     = 500;
  // strictly longer than the refresh entry period
  localparam int PAR_CYC    = (PAR_NS + CLK_NS - 1) / CLK_NS + 1;

  // first-data latency in link clocks
  localparam logic [2:0] LAT_66 = 3'h5;
  localparam logic [2:0] LAT_54 = 3'h4;

  // burst lengths in words
  localparam logic [8:0] BL_4    = 9'h004;
  localparam logic [8:0] BL_8    = 9'h008;
  localparam logic [8:0] BL_16   = 9'h010;
  localparam logic [8:0] BL_PAGE = 9'h100;

  // mode word fields, loaded from the address pins
  localparam int MD_BL_LSB  = 0;
  localparam int MD_BT_BIT  = 2;
  localparam int MD_PAR_LO  = 3;
  localparam int MD_PAR_HI  = 4;
  localparam int MD_IMS_LSB = 4;
  localparam int MD_LAT_BIT = 6;
  localparam logic [ADDR_W-1:0] MODE_RST = 22'h000000;

  localparam logic [1:0] IMS_ASYNC   = 2'h0;
  localparam logic [1:0] IMS_SYNC_RD = 2'h1;
  localparam logic [1:0] IMS_SYNC_RW = 2'h2;

  // register map
  localparam logic [AXI_AW-1:0] REG_MODE   = 8'h00;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
  localparam int STS_PWR_LSB = 0;
  localparam int STS_BST_LSB = 3;
  localparam int STS_DIR_BIT = 5;
  localparam int STS_IMS_LSB = 6;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {
    PWR_UP   = 3'b000,
    PWR_STBY = 3'b001,
    PWR_ACT  = 3'b010,
    PWR_PAR  = 3'b011
  } bpi_pwr_e;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_WAIT = 2'b01,
    B_RD   = 2'b10,
    B_WR   = 2'b11
  } bpi_burst_e;

  typedef struct packed {
    logic              cs_n;
    logic              mode_load_n;
    logic              oe_n;
    logic              we_n;
    logic              low_byte_lane_n;
    logic              high_byte_lane_n;
    logic              addr_strobe_n;
    logic              clk;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bpi_pin_in_s;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0]        data_oe;
    logic              read_hold_n;
    logic              read_hold_oe;
  } bpi_pin_out_s;
endpackage

// [logic/bpi_psram_dev.sv]
// Operation
// - operate only while selected, else standby
// - deselect terminates a running burst
// - drive read data only while output enabled
// - accept write data while write strobe low
// - byte lane enables pick low, high, word
// - address valid while address strobe low
// - mode load takes address as mode word
// - read hold low until read data valid
// - sync modes sample on link clock edges
// - power-up default async read/write
// - long mode load in standby enters refresh
// - mode load release returns to standby
// - bursts of 4, 8, 16, 256 words
// - linear or interleaved burst order
// - latency 5 or 4 clocks by mode
// - stopped link clock suspends burst
// - masked byte lanes skip burst write
// - sync read async write, sync read/write
// - two-bit select picks interface mode
// - async mode ignores clock, strobe, hold
module bpi_psram_dev
  import bpi_pkg::*;
#(
  parameter int unsigned PU_CYCLES = PU_CYC_DEF,
  parameter int unsigned MEM_AW    = ADDR_W
) (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [AXI_AW-1:0]   awaddr,
  input  wire logic                awvalid,
  output logic                     awready,
  input  wire logic [31:0]         wdata,
  input  wire logic [3:0]          wstrb,
  input  wire logic                wvalid,
  output logic                     wready,
  output logic [1:0]               bresp,
  output logic                     bvalid,
  input  wire logic                bready,
  input  wire logic [AXI_AW-1:0]   araddr,
  input  wire logic                arvalid,
  output logic                     arready,
  output logic [31:0]              rdata,
  output logic [1:0]               rresp,
  output logic                     rvalid,
  input  wire logic                rready,
  input  wire bpi_pin_in_s         pin_in,
  output bpi_pin_out_s             pin_out
);

  localparam int CW = $clog2(PU_CYCLES + PAR_CYC + 2);

  if (PU_CYCLES < 1 || MEM_AW < 4 || MEM_AW > ADDR_W) begin : g_chk
    $error("bpi_psram_dev: bad PU_CYCLES or MEM_AW");
  end

  logic [DATA_W-1:0] ram [2**MEM_AW];

  // pins are asynchronous to aclk; the link clock is sampled too,
  // which is why the host must stay far below aclk
  bpi_pin_in_s       s1_q;
  bpi_pin_in_s       s_q;
  logic              clk_d1_q;
  bpi_pwr_e          pwr_q;
  bpi_burst_e        bst_q;
  logic [CW-1:0]     cnt_q;
  logic [ADDR_W-1:0] mode_q;
  logic [ADDR_W-1:0] base_q;
  logic [BEAT_W-1:0] beat_q;
  logic [2:0]        lat_q;
  logic              dir_wr_q;
  bpi_pin_out_s      pout_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic [AXI_AW-1:0] aw_addr_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q     <= '1;
      s_q      <= '1;
      clk_d1_q <= 1'b1;
    end else begin
      s1_q     <= pin_in;
      s_q      <= s1_q;
      clk_d1_q <= s_q.clk;
    end
  end

  // mode decode
  wire [1:0] ims      = mode_q[MD_IMS_LSB +: 2];
  wire       async_md = (ims == IMS_ASYNC);
  wire       sync_wr  = (ims == IMS_SYNC_RW);
  wire       ileave   = mode_q[MD_BT_BIT];
  wire [2:0] lat_sel  = mode_q[MD_LAT_BIT] ? LAT_66 : LAT_54;
  wire [1:0] bl_fld   = mode_q[MD_BL_LSB +: 2];
  wire [8:0] blen     = (bl_fld == 2'h0) ? BL_4 :
                        (bl_fld == 2'h1) ? BL_8 :
                        (bl_fld == 2'h2) ? BL_16 : BL_PAGE;
  wire [7:0] bmask    = 8'(blen - 9'h001);
  wire       par_ok   = mode_q[MD_PAR_HI] & ~mode_q[MD_PAR_LO];

  // pin decode
  wire       sel       = ~s_q.cs_n;
  wire       active    = (pwr_q == PWR_ACT) & sel;
  wire       op_ok     = active & s_q.mode_load_n;
  wire [1:0] lane_en   = {~s_q.high_byte_lane_n,
                          ~s_q.low_byte_lane_n};
  wire       clk_rise  = s_q.clk & ~clk_d1_q;
  wire       idle      = (bst_q == B_IDLE);
  wire       mload     = active & ~s_q.mode_load_n & ~s_q.we_n;
  wire       async_wr  = op_ok & ~s_q.we_n & s_q.oe_n & ~sync_wr
                         & idle;
  wire       async_rd  = op_ok & async_md & s_q.we_n;
  // strobe ignored in async mode; strobe may stay low for a
  // back-to-back restart after the burst ends
  wire       cmd       = op_ok & ~async_md & clk_rise & idle
                         & ~s_q.addr_strobe_n
                         & (s_q.we_n | sync_wr);
  wire       cmd_wr    = ~s_q.we_n;
  // no link edge means no beat: a stopped clock suspends
  wire       beat_edge = active & clk_rise & ~idle;
  wire       lat_done  = (bst_q == B_WAIT) & (lat_q == 3'h1);
  wire       last_rd   = (beat_q == blen);
  wire       last_wr   = (beat_q == blen - 9'h001);

  // burst address sequence
  wire [7:0] b_lo   = base_q[7:0];
  wire [7:0] b_step = beat_q[7:0];
  wire [7:0] seq    = ileave ? (b_lo ^ b_step)
                             : 8'(b_lo + b_step);
  wire [ADDR_W-1:0] bidx = {base_q[ADDR_W-1:8],
                            (b_lo & ~bmask) | (seq & bmask)};

  wire [ADDR_W-1:0] ra    = idle ? s_q.addr : bidx;
  wire [DATA_W-1:0] rword = ram[ra[MEM_AW-1:0]];
  wire ld_rd = async_rd
             | (beat_edge & lat_done & ~dir_wr_q)
             | (beat_edge & (bst_q == B_RD) & ~last_rd);
  wire wr_burst = beat_edge & (bst_q == B_WR);
  wire mem_we   = async_wr | wr_burst;
  wire [ADDR_W-1:0] wa = idle ? s_q.addr : bidx;

  wire rd_drv = op_ok & ~s_q.oe_n & s_q.we_n
              & (async_md | (bst_q == B_RD));
  wire hold_oe = op_ok & ~async_md;
  wire hold_n  = ~((bst_q == B_WAIT) & ~dir_wr_q);

  // power state
  wire cond_pu   = s_q.cs_n & s_q.mode_load_n;
  wire pu_done   = (cnt_q == CW'(PU_CYCLES - 1));
  wire par_done  = (cnt_q == CW'(PAR_CYC - 1));
  wire par_low   = (pwr_q == PWR_STBY) & s_q.cs_n
                   & ~s_q.mode_load_n;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q <= PWR_UP;
      cnt_q <= '0;
    end else begin
      case (pwr_q)
        PWR_UP: begin
          cnt_q <= cond_pu ? CW'(cnt_q + 1'b1) : '0;
          if (cond_pu && pu_done) begin
            pwr_q <= PWR_STBY;
            cnt_q <= '0;
          end
        end
        PWR_STBY: begin
          cnt_q <= par_low ? CW'(cnt_q + 1'b1) : '0;
          if (sel) begin
            pwr_q <= PWR_ACT;
          end else if (par_low && par_done && par_ok) begin
            pwr_q <= PWR_PAR;
          end
        end
        PWR_ACT: begin
          cnt_q <= '0;
          if (!sel) begin
            pwr_q <= PWR_STBY;
          end
        end
        PWR_PAR: begin
          cnt_q <= '0;
          if (s_q.mode_load_n) begin
            pwr_q <= PWR_STBY;
          end
        end
        default: begin
          pwr_q <= PWR_UP;
          cnt_q <= '0;
        end
      endcase
    end
  end

  // burst sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bst_q    <= B_IDLE;
      base_q   <= '0;
      beat_q   <= '0;
      lat_q    <= '0;
      dir_wr_q <= 1'b0;
    end else if (!active || !s_q.mode_load_n) begin
      bst_q <= B_IDLE;
    end else if (cmd) begin
      base_q   <= s_q.addr;
      beat_q   <= '0;
      lat_q    <= lat_sel - 3'h1;
      dir_wr_q <= cmd_wr;
      bst_q    <= B_WAIT;
    end else if (beat_edge) begin
      case (bst_q)
        B_WAIT: begin
          lat_q <= lat_q - 3'h1;
          if (lat_done) begin
            bst_q  <= dir_wr_q ? B_WR : B_RD;
            beat_q <= dir_wr_q ? '0 : 9'h001;
          end
        end
        B_RD: begin
          beat_q <= beat_q + 9'h001;
          if (last_rd) begin
            bst_q <= B_IDLE;
          end
        end
        B_WR: begin
          beat_q <= beat_q + 9'h001;
          if (last_wr) begin
            bst_q <= B_IDLE;
          end
        end
        default: bst_q <= B_IDLE;
      endcase
    end
  end

  // array write, per byte lane
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 2; i++) begin
      if (mem_we && lane_en[i]) begin
        ram[wa[MEM_AW-1:0]][i*8 +: 8] <= s_q.data[i*8 +: 8];
      end
    end
  end

  // pin outputs, all from flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pout_q <= '{data: '0, data_oe: 2'h0, read_hold_n: 1'b1,
                  read_hold_oe: 1'b0};
    end else begin
      if (ld_rd) begin
        pout_q.data <= rword;
      end
      pout_q.data_oe      <= {2{rd_drv}} & lane_en;
      pout_q.read_hold_n  <= hold_n;
      pout_q.read_hold_oe <= hold_oe;
    end
  end
  assign pin_out = pout_q;

  // register slave: write address and data in either order
  wire do_wr  = aw_have_q & w_have_q & ~bvalid;
  wire wr_mod = (aw_addr_q == REG_MODE);
  wire wr_sts = (aw_addr_q == REG_STATUS);
  wire [31:0] mode_ext = {{(32-ADDR_W){1'b0}}, mode_q};
  logic [31:0] mode_mrg;
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      mode_mrg[b*8 +: 8] = w_strb_q[b] ? w_data_q[b*8 +: 8]
                                       : mode_ext[b*8 +: 8];
    end
  end

  // a pin mode load outranks a bus write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= MODE_RST;
    end else if (mload) begin
      mode_q <= s_q.addr;
    end else if (do_wr && wr_mod) begin
      mode_q <= mode_mrg[ADDR_W-1:0];
    end
  end

  assign awready = ~aw_have_q;
  assign wready  = ~w_have_q;
  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
    end else begin
      if (awvalid && !aw_have_q) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && !w_have_q) begin
        w_have_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= (wr_mod | wr_sts) ? RESP_OKAY : RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // status fields at their named places; spare bits read zero
  logic [31:0] sts_word;
  always_comb begin
    sts_word                   = 32'h00000000;
    sts_word[STS_PWR_LSB +: 3] = pwr_q;
    sts_word[STS_BST_LSB +: 2] = bst_q;
    sts_word[STS_DIR_BIT]      = dir_wr_q;
    sts_word[STS_IMS_LSB +: 2] = ims;
  end
  wire rd_mod = (araddr == REG_MODE);
  wire rd_sts = (araddr == REG_STATUS);
  wire [31:0] rd_mux = rd_mod ? mode_ext :
                       rd_sts ? sts_word : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= RESP_OKAY;
    end else if (arvalid && !rvalid) begin
      rvalid <= 1'b1;
      rdata  <= rd_mux;
      rresp  <= (rd_mod | rd_sts) ? RESP_OKAY : RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// [testbench/bpi_host_model.sv]
module bpi_host_model
  import bpi_pkg::*;
(
  input  wire logic aclk,
  output bpi_pin_in_s pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // the pin sampler needs at least 3 aclk per phase
  localparam int HALF = 4;

  // chip select high first, mode load high second
  initial begin
    pin = {7'h5f, 1'b0, 22'h0, 16'h0};
    #1 pin.mode_load_n = 1'b1;
  end

  // reads release the data line, which then reads back as the inverse
  task automatic drv(input logic [6:0] c, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    @(posedge aclk);
    pin <= {c, pin.clk, a, c[3] ? ~pin.data : d};
    repeat (3) @(posedge aclk);
  endtask

  // link clock stands still between calls, 12.5 MHz within a frame
  task automatic rise();
    @(posedge aclk);
    pin.clk <= 1'b1;
    repeat (HALF) @(posedge aclk);
    pin.clk <= 1'b0;
    repeat (HALF - 1) @(posedge aclk);
  endtask
endmodule

// [testbench/bpi_psram_dev_chk.sv]
module bpi_psram_dev_chk
  import bpi_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [AXI_AW-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire bpi_pin_in_s       pin_in,
  input wire bpi_pin_out_s      pin_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence

  // six samples cover two input flops and the output flop
  a_desel_quiet: assert property (
    pin_in.cs_n [*6] |-> pin_out.data_oe == 2'h0)
    else $error("data driven while deselected");
  a_oe_gates_data: assert property (
    pin_in.oe_n [*6] |-> pin_out.data_oe == 2'h0)
    else $error("data driven with output enable off");
  a_low_lane_off: assert property (
    pin_in.low_byte_lane_n [*6] |-> !pin_out.data_oe[0])
    else $error("low byte driven while unselected");
  a_high_lane_off: assert property (
    pin_in.high_byte_lane_n [*6] |-> !pin_out.data_oe[1])
    else $error("high byte driven while unselected");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_rd_taken |=> rvalid)
    else $error("read data late");
  a_read_decerr: assert property (
    s_rd_taken ##0 (araddr != REG_MODE && araddr != REG_STATUS)
    |=> rresp == RESP_DECERR && rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rdata_stands: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
endmodule

bind bpi_psram_dev bpi_psram_dev_chk i_chk (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
  .pin_in, .pin_out
);

// [testbench/tb_bpi_psram_dev.sv]
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
  mismatches++; $display("Error %s expected %0h seen %0h", nm, ex, got); \
  end end

module tb_bpi_psram_dev;
  import bpi_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  // pin controls: cs, mode load, oe, we, low lane, high lane, strobe
  localparam logic [6:0] C_WR = 7'h31, C_WRH = 7'h35, C_RDL = 7'h2b;
  localparam logic [6:0] C_RD = 7'h29, C_IDLE = 7'h39, C_DSEL = 7'h7f;
  localparam logic [6:0] C_ML = 7'h11, C_CMD = 7'h28, C_PAR = 7'h5f;
  localparam logic [6:0] C_WCMD = 7'h30;

  logic              aclk, aresetn, awvalid, awready, wvalid, wready;
  logic              bvalid, bready, arvalid, arready, rvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rs;
  bpi_pin_in_s       pin_in;
  bpi_pin_out_s      pin_out;
  int                mismatches, n_compared;

  bpi_psram_dev #(.PU_CYCLES(20), .MEM_AW(10)) i_dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .pin_in, .pin_out);
  bpi_host_model i_host (.aclk, .pin(pin_in));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic axw(input logic [AXI_AW-1:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    // late ready lets the response stand a cycle
    while (!bvalid) @(posedge aclk);
    bready <= 1'b1;
    @(posedge aclk);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b1;
    @(posedge aclk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic t_regs;
    axr(REG_MODE, rd, rs);
    `CHK("mode reset", 32'h0, rd)
    axr(REG_STATUS, rd, rs);
    `CHK("power-up state", PWR_UP, rd[2:0])
    repeat (30) @(posedge aclk);
    axr(REG_STATUS, rd, rs);
    `CHK("standby after wait", PWR_STBY, rd[2:0])
    axr(8'h08, rd, rs);
    `CHK("unmapped read", RESP_DECERR, rs)
    axw(8'h0c, 32'h1, rs);
    `CHK("unmapped write", RESP_DECERR, rs)
    axw(REG_STATUS, 32'hff, rs);
    `CHK("status write", RESP_OKAY, rs)
    axr(REG_STATUS, rd, rs);
    `CHK("status read only", PWR_STBY, rd[2:0])
    axw(REG_MODE, 32'hffffffff, rs);
    axr(REG_MODE, rd, rs);
    `CHK("mode write", 32'h003fffff, rd)
    axw(REG_MODE, 32'h0, rs);
    axr(REG_MODE, rd, rs);
    `CHK("mode cleared", 32'h0, rd)
    $display("regs test done");
  endtask

  task automatic t_async;
    i_host.drv(C_WR, 22'h5, 16'h1234);
    i_host.drv(C_WRH, 22'h5, 16'habcd);
    i_host.drv(C_RDL, 22'h5, 16'h0);
    repeat (3) @(posedge aclk);
    `CHK("low lane oe", 2'h1, pin_out.data_oe)
    `CHK("low lane data", 8'h34, pin_out.data[7:0])
    `CHK("hold pin released", 1'b0, pin_out.read_hold_oe)
    i_host.drv(C_RD, 22'h5, 16'h0);
    repeat (3) @(posedge aclk);
    `CHK("lane write", 16'hab34, pin_out.data)
    for (int i = 8; i < 12; i++) i_host.drv(C_WR, 22'(i), 16'h5a00 + 16'(i));
    i_host.drv(C_DSEL, 22'h0, 16'h0);
    axr(REG_STATUS, rd, rs);
    `CHK("deselect standby", PWR_STBY, rd[2:0])
    $display("async test done");
  endtask

  task automatic t_burst;
    logic [21:0] md [2] = '{22'h10, 22'h54};
    logic [21:0] base [2] = '{22'ha, 22'h9};
    logic [21:0] a;
    int lat;
    for (int c = 0; c < 2; c++) begin
      i_host.drv(C_ML, md[c], 16'h0);
      i_host.drv(C_DSEL, 22'h0, 16'h0);
      axr(REG_MODE, rd, rs);
      `CHK("mode from pins", md[c], rd[21:0])
      lat = md[c][MD_LAT_BIT] ? LAT_66 : LAT_54;
      i_host.drv(C_CMD, base[c], 16'h0);
      i_host.rise();
      i_host.drv(C_RD, base[c], 16'h0);
      i_host.rise();
      `CHK("hold before data", 1'b0, pin_out.read_hold_n)
      repeat (lat - 2) i_host.rise();
      `CHK("hold at data", 1'b1, pin_out.read_hold_n)
      `CHK("hold pin driven", 1'b1, pin_out.read_hold_oe)
      `CHK("burst lanes driven", 2'h3, pin_out.data_oe)
      for (int k = 0; k < (c ? 2 : 4); k++) begin
        if (k > 0) i_host.rise();
        a = md[c][MD_BT_BIT] ? base[c] ^ 22'(k)
                             : {base[c][21:2], 2'(base[c][1:0] + k)};
        `CHK("burst word", 16'h5a00 + a[15:0], pin_out.data)
      end
      // second burst stops mid-way: clock held, then deselected
      if (c == 1) begin
        repeat (20) @(posedge aclk);
        `CHK("suspended word", 16'h5a00 + a[15:0], pin_out.data)
        axr(REG_STATUS, rd, rs);
        `CHK("burst running", 2'h2, rd[STS_BST_LSB +: 2])
      end
      i_host.drv(C_DSEL, 22'h0, 16'h0);
      axr(REG_STATUS, rd, rs);
      `CHK("burst ended", 2'h0, rd[STS_BST_LSB +: 2])
    end
    $display("burst test done");
  endtask

  task automatic t_par;
    i_host.drv(C_PAR, 22'h0, 16'h0);
    repeat (60) @(posedge aclk);
    axr(REG_STATUS, rd, rs);
    `CHK("refresh region", PWR_PAR, rd[2:0])
    i_host.drv(C_DSEL, 22'h0, 16'h0);
    axr(REG_STATUS, rd, rs);
    `CHK("back to standby", PWR_STBY, rd[2:0])
    $display("refresh test done");
  endtask

  // sync write burst with one masked lane, read back in async mode
  task automatic t_wburst;
    logic [15:0] want [4] = '{16'hc1c3, 16'hc1c0, 16'hc10a, 16'hc1c2};
    i_host.drv(C_ML, 22'h20, 16'h0);
    i_host.drv(C_WCMD, 22'h9, 16'h0);
    i_host.rise();
    i_host.drv(C_WR, 22'h9, 16'h0);
    repeat (LAT_54 - 1) i_host.rise();
    for (int k = 0; k < 4; k++) begin
      i_host.drv(k == 1 ? C_WRH : C_WR, 22'h9, 16'hc1c0 + 16'(k));
      i_host.rise();
    end
    axr(REG_STATUS, rd, rs);
    `CHK("write burst ended", 2'h0, rd[STS_BST_LSB +: 2])
    i_host.drv(C_IDLE, 22'h0, 16'h0);
    axw(REG_MODE, 32'h0, rs);
    `CHK("mode write resp", RESP_OKAY, rs)
    for (int i = 0; i < 4; i++) begin
      i_host.drv(C_RD, 22'h8 + 22'(i), 16'h0);
      repeat (3) @(posedge aclk);
      `CHK("burst written word", want[i], pin_out.data)
    end
    $display("write burst test done");
  endtask

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_async();
    t_burst();
    t_par();
    t_wburst();
    conclude();
  end
endmodule
